//--- spd_pkg.sv
package spd_pkg;

  // Bus address width: a 16-bit register index shifted left by two.
  localparam int ADDR_W = 18;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_SYNC_SEL    = 16'h0036;
  localparam logic [15:0] IDX_PLL_FACTOR  = 16'h0037;
  localparam logic [15:0] IDX_SYSREF_MASK = 16'h003e;
  localparam logic [15:0] DEC_BASE_A      = 16'h5000;
  localparam logic [15:0] DEC_BASE_B      = 16'h5800;
  localparam logic [15:0] IDX_DEC_ENABLE  = 16'h0000;
  localparam logic [15:0] IDX_DEC_RATIO   = 16'h0001;

  localparam logic [ADDR_W-1:0] ADR_SYNC_SEL    = {IDX_SYNC_SEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PLL_FACTOR  = {IDX_PLL_FACTOR, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_SYSREF_MASK = {IDX_SYSREF_MASK, 2'b00};

  // Field positions.
  localparam int SYNC_SEL_BIT    = 6;
  localparam int CLKDIV_MASK_BIT = 6;
  localparam int NCO_MASK_BIT    = 5;
  localparam int DEC_ENABLE_BIT  = 0;
  localparam int PLL_FIELD_W     = 2;
  localparam int RATIO_FIELD_W   = 4;

  // Values after reset.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Serializer PLL codes and the multiplication each selects.
  localparam logic [1:0] PLL_CODE_20X = 2'h0;
  localparam logic [1:0] PLL_CODE_16X = 2'h1;
  localparam logic [1:0] PLL_CODE_40X = 2'h2;
  localparam logic [1:0] PLL_CODE_80X = 2'h3;
  localparam logic [6:0] PLL_MULT_20  = 7'h14;
  localparam logic [6:0] PLL_MULT_16  = 7'h10;
  localparam logic [6:0] PLL_MULT_40  = 7'h28;
  localparam logic [6:0] PLL_MULT_80  = 7'h50;

  // Decimation ratio code that selects divide-by-24.
  localparam logic [3:0] RATIO_CODE_24 = 4'ha;

  typedef struct packed {
    logic       decim_active;
    logic       bypass;
    logic [5:0] ratio;
    logic       ratio_valid;
  } spd_chan_cfg_t;

  typedef struct packed {
    logic clkdiv_reset;
    logic nco_phase_reset;
    logic lmfc_reset;
  } spd_sysref_evt_t;

  function automatic logic [6:0] pll_mult_of(input logic [1:0] code);
    logic [6:0] m;
    m = PLL_MULT_20;
    case (code)
      PLL_CODE_20X: m = PLL_MULT_20;
      PLL_CODE_16X: m = PLL_MULT_16;
      PLL_CODE_40X: m = PLL_MULT_40;
      PLL_CODE_80X: m = PLL_MULT_80;
      default:      m = PLL_MULT_20;
    endcase
    return m;
  endfunction

  // Complex decimation ratio for a code; zero marks an unused code.
  function automatic logic [5:0] ratio_of(input logic [3:0] code);
    logic [5:0] r;
    r = 6'h00;
    case (code)
      4'h0:          r = 6'h04;
      4'h1:          r = 6'h06;
      4'h2:          r = 6'h08;
      4'h3:          r = 6'h09;
      4'h4:          r = 6'h0a;
      4'h5:          r = 6'h0c;
      4'h7:          r = 6'h10;
      4'h8:          r = 6'h12;
      4'h9:          r = 6'h14;
      RATIO_CODE_24: r = 6'h18;
      4'hc:          r = 6'h20;
      default:       r = 6'h00;
    endcase
    return r;
  endfunction

  // Byte address of a decimation page register for channel A (0) or B (1).
  function automatic logic [ADDR_W-1:0] chan_addr(input logic ch, input logic [15:0] idx);
    logic [15:0] full;
    full = (ch ? DEC_BASE_B : DEC_BASE_A) + idx;
    return {full, 2'b00};
  endfunction

endpackage

//--- spd_decim_chan.sv
`timescale 1ns/10ps
module spd_decim_chan (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Channel settings.
  input  wire logic               enable,
  input  wire logic [3:0]         ratio_code,
  // Datapath control.
  output spd_pkg::spd_chan_cfg_t  cfg
);
  import spd_pkg::*;

  logic [5:0]    ratio_val;
  spd_chan_cfg_t nxt_cfg;
  spd_chan_cfg_t cfg_ff;

  assign ratio_val            = ratio_of(ratio_code);  // see [R8] see [R9]
  assign nxt_cfg.decim_active = enable;                // see [R7]
  assign nxt_cfg.bypass       = ~enable;               // see [R7]
  assign nxt_cfg.ratio        = ratio_val;
  assign nxt_cfg.ratio_valid  = (ratio_val != 6'h00);
  assign cfg                  = cfg_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '{decim_active: 1'b0, bypass: 1'b1, ratio: 6'h04, ratio_valid: 1'b1};
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  chk_bypass_exclusive: assert property (@(posedge clk) disable iff (!rst_n) // see [R7]
    cfg.bypass == !cfg.decim_active) else $error("bypass and decimation both on or both off");

  chk_enable_follows: assert property (@(posedge clk) disable iff (!rst_n) // see [R7]
    $rose(enable) |=> cfg.decim_active && !cfg.bypass) else $error("decimator not enabled after set");

  chk_ratio_twentyfour: assert property (@(posedge clk) disable iff (!rst_n) // see [R9]
    ratio_code == RATIO_CODE_24 |=> cfg.ratio == 6'h18 && cfg.ratio_valid) else $error("code 1010 not divide-by-24");

  chk_ratio_unused: assert property (@(posedge clk) disable iff (!rst_n) // see [R8]
    (ratio_code == 4'h6 || ratio_code == 4'hb) |=> !cfg.ratio_valid) else $error("unused ratio code reported valid");

  chk_ratio_thirtytwo: assert property (@(posedge clk) disable iff (!rst_n) // see [R8]
    ratio_code == 4'hc |=> cfg.ratio == 6'h20) else $error("code 1100 not divide-by-32");

endmodule

//--- spd_sync_pll_decim_regs.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
// Overview of operation
// [R1] Sync select bit 6 set takes sync request from general pin, else differential.
// [R2] PLL field 1-0 selects 20X, 16X, 40x or 80x multiplication.
// [R3] Software choosing 40x must also program the separate forty_times_enable_field field.
// [R4] That forty_times_enable_field field holds 111 for 40x, 000 for 20X or 80X.
// [R5] Clock divider resets on each SYSREF rise unless its mask bit 6 set.
// [R6] NCO phase and LMFC reset on SYSREF rise unless mask bit 5 set.
// [R7] Decimator enable bit 0 clear bypasses the filter; set activates it.
// [R8] Ratio field 3-0 selects complex decimation; codes 0110 and 1011 unused.
// [R9] Code 1010 selects divide-by-24.
// [R10] Decimation page direct addressed: channel A at 5000h, channel B 5800h.
// [R11] Reserved bits are written zero by software and have no effect.
module spd_sync_pll_decim_regs (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // AHB-Lite slave.
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Sync request sources and selected request.
  input  wire logic                          sync_diff_n,
  input  wire logic                          general_pin_four,
  output logic                               sync_req_n,
  // SYSREF input and the resets it produces.
  input  wire logic                          sysref,
  output spd_pkg::spd_sysref_evt_t           sysref_evt,
  // Serializer PLL multiplication.
  output logic [6:0]                         pll_mult,
  // Per-channel decimation control, index 0 channel A, 1 channel B.
  output spd_pkg::spd_chan_cfg_t [1:0]       chan_cfg
);
  import spd_pkg::*;

  // Register state.
  logic                     single_ended_sync_select_ff;
  logic [PLL_FIELD_W-1:0]   pll_factor_ff;
  logic                     divider_sysref_mask_ff;
  logic                     oscillator_frame_sysref_mask_ff;
  logic [1:0]               decimator_enable_bit_ff;
  logic [RATIO_FIELD_W-1:0] decimation_ratio_field_ff [2];

  // Bus state.
  logic              wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [31:0]       hrdata_ff;
  logic              hreadyout_ff;
  logic              hresp_ff;

  // Outputs held in flops, and the previous SYSREF sample.
  logic            sync_req_n_ff;
  logic            sysref_prev_ff;
  spd_sysref_evt_t sysref_evt_ff;
  logic [6:0]      pll_mult_ff;

  // Next values.
  logic                     nxt_single_ended_sync_select;
  logic [PLL_FIELD_W-1:0]   nxt_pll_factor;
  logic                     nxt_divider_sysref_mask;
  logic                     nxt_oscillator_frame_sysref_mask;
  logic [1:0]               nxt_decimator_enable_bit;
  logic [RATIO_FIELD_W-1:0] nxt_decimation_ratio_field [2];
  logic [31:0]              nxt_hrdata;

  // Bus decode and SYSREF rise detect.
  wire              addr_phase = hsel && htrans[1] && hready;
  wire              rd_req     = addr_phase && !hwrite;
  wire [ADDR_W-1:0] rd_addr    = haddr[ADDR_W-1:0];
  wire              rd_in_map  = (haddr[31:ADDR_W] == '0);
  wire              wr_sync    = wr_pend_ff && (wr_addr_ff == ADR_SYNC_SEL);
  wire              wr_pll     = wr_pend_ff && (wr_addr_ff == ADR_PLL_FACTOR);
  wire              wr_mask    = wr_pend_ff && (wr_addr_ff == ADR_SYSREF_MASK);
  wire              sysref_rise = sysref && !sysref_prev_ff;

  // Writes take effect at the end of the data phase; reserved bits are dropped.
  assign nxt_single_ended_sync_select = wr_sync ? hwdata[SYNC_SEL_BIT] : single_ended_sync_select_ff;
  assign nxt_pll_factor               = wr_pll ? hwdata[PLL_FIELD_W-1:0] : pll_factor_ff;  // see [R11]
  assign nxt_divider_sysref_mask      = wr_mask ? hwdata[CLKDIV_MASK_BIT] : divider_sysref_mask_ff;
  assign nxt_oscillator_frame_sysref_mask = wr_mask ? hwdata[NCO_MASK_BIT] : oscillator_frame_sysref_mask_ff;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire wr_en    = wr_pend_ff && (wr_addr_ff == chan_addr(1'(ch), IDX_DEC_ENABLE));  // see [R10]
    wire wr_ratio = wr_pend_ff && (wr_addr_ff == chan_addr(1'(ch), IDX_DEC_RATIO));   // see [R10]
    assign nxt_decimator_enable_bit[ch]   = wr_en ? hwdata[DEC_ENABLE_BIT] : decimator_enable_bit_ff[ch];
    assign nxt_decimation_ratio_field[ch] = wr_ratio ? hwdata[RATIO_FIELD_W-1:0]
                                                     : decimation_ratio_field_ff[ch];
    spd_decim_chan u_chan (
      .clk        (clk),
      .rst_n      (rst_n),
      .enable     (decimator_enable_bit_ff[ch]),
      .ratio_code (decimation_ratio_field_ff[ch]),
      .cfg        (chan_cfg[ch])
    );
  end

  // Read data uses next values so a read right after a write sees the new value.
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    if (!rd_req || !rd_in_map) begin
      nxt_hrdata = 32'h0000_0000;
    end else if (rd_addr == ADR_SYNC_SEL) begin
      nxt_hrdata[SYNC_SEL_BIT] = nxt_single_ended_sync_select;
    end else if (rd_addr == ADR_PLL_FACTOR) begin
      nxt_hrdata[PLL_FIELD_W-1:0] = nxt_pll_factor;
    end else if (rd_addr == ADR_SYSREF_MASK) begin
      nxt_hrdata[CLKDIV_MASK_BIT] = nxt_divider_sysref_mask;
      nxt_hrdata[NCO_MASK_BIT]    = nxt_oscillator_frame_sysref_mask;
    end else if (rd_addr == chan_addr(1'b0, IDX_DEC_ENABLE)) begin   // see [R10]
      nxt_hrdata[DEC_ENABLE_BIT] = nxt_decimator_enable_bit[0];
    end else if (rd_addr == chan_addr(1'b1, IDX_DEC_ENABLE)) begin
      nxt_hrdata[DEC_ENABLE_BIT] = nxt_decimator_enable_bit[1];
    end else if (rd_addr == chan_addr(1'b0, IDX_DEC_RATIO)) begin
      nxt_hrdata[RATIO_FIELD_W-1:0] = nxt_decimation_ratio_field[0];
    end else if (rd_addr == chan_addr(1'b1, IDX_DEC_RATIO)) begin
      nxt_hrdata[RATIO_FIELD_W-1:0] = nxt_decimation_ratio_field[1];
    end
  end

  // Bus slave: zero wait states, always OKAY.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= '0;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= addr_phase && hwrite && rd_in_map;
      wr_addr_ff   <= rd_addr;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // Register file.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      single_ended_sync_select_ff     <= REG_RESET[SYNC_SEL_BIT];
      pll_factor_ff                   <= REG_RESET[PLL_FIELD_W-1:0];
      divider_sysref_mask_ff          <= REG_RESET[CLKDIV_MASK_BIT];
      oscillator_frame_sysref_mask_ff <= REG_RESET[NCO_MASK_BIT];
      decimator_enable_bit_ff         <= {2{REG_RESET[DEC_ENABLE_BIT]}};
      decimation_ratio_field_ff[0]    <= REG_RESET[RATIO_FIELD_W-1:0];
      decimation_ratio_field_ff[1]    <= REG_RESET[RATIO_FIELD_W-1:0];
    end else begin
      single_ended_sync_select_ff     <= nxt_single_ended_sync_select;
      pll_factor_ff                   <= nxt_pll_factor;
      divider_sysref_mask_ff          <= nxt_divider_sysref_mask;
      oscillator_frame_sysref_mask_ff <= nxt_oscillator_frame_sysref_mask;
      decimator_enable_bit_ff         <= nxt_decimator_enable_bit;
      decimation_ratio_field_ff[0]    <= nxt_decimation_ratio_field[0];
      decimation_ratio_field_ff[1]    <= nxt_decimation_ratio_field[1];
    end
  end

  // Sync source, SYSREF resets and PLL factor.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_req_n_ff  <= 1'b1;
      sysref_prev_ff <= 1'b0;
      sysref_evt_ff  <= '0;
      pll_mult_ff    <= PLL_MULT_20;
    end else begin
      sync_req_n_ff  <= single_ended_sync_select_ff ? general_pin_four : sync_diff_n;  // see [R1]
      sysref_prev_ff <= sysref;
      sysref_evt_ff.clkdiv_reset    <= sysref_rise && !divider_sysref_mask_ff;           // see [R5]
      sysref_evt_ff.nco_phase_reset <= sysref_rise && !oscillator_frame_sysref_mask_ff;  // see [R6]
      sysref_evt_ff.lmfc_reset      <= sysref_rise && !oscillator_frame_sysref_mask_ff;  // see [R6]
      pll_mult_ff    <= pll_mult_of(pll_factor_ff);                                      // see [R2]
    end
  end

  assign hrdata     = hrdata_ff;
  assign hreadyout  = hreadyout_ff;
  assign hresp      = hresp_ff;
  assign sync_req_n = sync_req_n_ff;
  assign sysref_evt = sysref_evt_ff;
  assign pll_mult   = pll_mult_ff;

  chk_sync_single_ended: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
    single_ended_sync_select_ff |=> sync_req_n == $past(general_pin_four)) else $error("sync not from general pin");

  chk_sync_differential: assert property (@(posedge clk) disable iff (!rst_n) // see [R1]
    !single_ended_sync_select_ff |=> sync_req_n == $past(sync_diff_n)) else $error("sync not from differential input");

  chk_pll_forty: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
    wr_pll && hwdata[1:0] == PLL_CODE_40X |=> ##1 pll_mult == PLL_MULT_40) else $error("40x code gave wrong factor");

  chk_pll_sixteen: assert property (@(posedge clk) disable iff (!rst_n) // see [R2]
    pll_factor_ff == PLL_CODE_16X |=> pll_mult == PLL_MULT_16) else $error("16X code gave wrong factor");

  chk_clkdiv_sysref: assert property (@(posedge clk) disable iff (!rst_n) // see [R5]
    $rose(sysref) |=> sysref_evt.clkdiv_reset == !$past(divider_sysref_mask_ff)) else $error("divider reset mismatch");

  chk_clkdiv_single: assert property (@(posedge clk) disable iff (!rst_n) // see [R5]
    sysref_evt.clkdiv_reset |=> !sysref_evt.clkdiv_reset) else $error("divider reset longer than one cycle");

  chk_nco_lmfc_pair: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
    sysref_evt.nco_phase_reset == sysref_evt.lmfc_reset) else $error("NCO and LMFC resets differ");

  chk_nco_masked: assert property (@(posedge clk) disable iff (!rst_n) // see [R6]
    oscillator_frame_sysref_mask_ff && $stable(oscillator_frame_sysref_mask_ff) |=> !sysref_evt.nco_phase_reset)
    else $error("masked SYSREF reset the NCO");

  chk_chan_b_enable: assert property (@(posedge clk) disable iff (!rst_n) // see [R10]
    addr_phase && hwrite && rd_in_map && rd_addr == chan_addr(1'b1, IDX_DEC_ENABLE) ##1 hwdata[0]
    |-> ##2 chan_cfg[1].decim_active) else $error("channel B enable write lost");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // see [R11]
    hrdata[31:8] == 24'h000000 && hresp == 1'b0) else $error("reserved read bits not zero");

  cov_write_then_read: cover property (@(posedge clk) disable iff (!rst_n)
    wr_mask ##2 rd_req && rd_addr == ADR_SYSREF_MASK);
  cov_sysref_reset: cover property (@(posedge clk) disable iff (!rst_n)
    sysref_evt.clkdiv_reset && sysref_evt.nco_phase_reset);
  cov_pll_forty: cover property (@(posedge clk) disable iff (!rst_n) pll_mult == PLL_MULT_40);
  cov_both_channels: cover property (@(posedge clk) disable iff (!rst_n)
    chan_cfg[0].decim_active && chan_cfg[1].decim_active);

endmodule

//--- spd_sync_pll_decim_regs_tb.sv
`timescale 1ns/10ps
module spd_sync_pll_decim_regs_tb;
  import spd_pkg::*;

  logic                     clk;
  logic                     rst_n;
  logic                     hsel;
  logic [31:0]              haddr;
  logic [1:0]               htrans;
  logic                     hwrite;
  logic [2:0]               hsize;
  logic [31:0]              hwdata;
  logic [31:0]              hrdata;
  logic                     hreadyout;
  logic                     hresp;
  logic                     sync_diff_n;
  logic                     general_pin_four;
  logic                     sync_req_n;
  logic                     sysref;
  spd_sysref_evt_t          sysref_evt;
  logic [6:0]               pll_mult;
  spd_chan_cfg_t [1:0]      chan_cfg;
  int                       err_total;
  int                       checks_done;
  logic [31:0]              seed;
  logic [31:0]              mdl [logic [31:0]];
  logic [31:0]              maps [7];
  int                       rtab [16] = '{4, 6, 8, 9, 10, 12, 0, 16, 18, 20, 24, 0, 32, 0, 0, 0};
  int                       ptab [4] = '{20, 16, 40, 80};

  spd_sync_pll_decim_regs DUT (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sync_diff_n(sync_diff_n), .general_pin_four(general_pin_four), .sync_req_n(sync_req_n),
    .sysref(sysref), .sysref_evt(sysref_evt), .pll_mult(pll_mult), .chan_cfg(chan_cfg)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] dec_adr(input logic ch, input logic [15:0] idx);
    logic [15:0] f;
    f = (ch ? DEC_BASE_B : DEC_BASE_A) + idx;
    return {14'h0, f, 2'b00};
  endfunction

  function automatic logic [31:0] fld_mask(input logic [31:0] a);
    fld_mask = 32'h0;
    if (a == 32'h0000_00d8) fld_mask = 32'h40;
    if (a == 32'h0000_00dc) fld_mask = 32'h03;
    if (a == 32'h0000_00f8) fld_mask = 32'h60;
    if (a == dec_adr(1'b0, 16'h0) || a == dec_adr(1'b1, 16'h0)) fld_mask = 32'h01;
    if (a == dec_adr(1'b0, 16'h1) || a == dec_adr(1'b1, 16'h1)) fld_mask = 32'h0f;
  endfunction

  // Expected datapath control of one channel from the model's register copies.
  function automatic logic [8:0] cfg_exp(input logic ch);
    logic en;
    int   r;
    en = mdl[dec_adr(ch, 16'h0)][0];
    r  = rtab[mdl[dec_adr(ch, 16'h1)][3:0]];
    return {en, ~en, r[5:0], r != 0};
  endfunction

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  // One single AHB-Lite transfer; the address phase is held until hready is seen high.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk_out({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    if (fld_mask(a) != 32'h0) mdl[a] = d & fld_mask(a);
  endtask

  task automatic rd_chk(input logic [31:0] a);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_rd(r, mdl.exists(a) ? mdl[a] : 32'h0);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check_all_regs();
    foreach (maps[i]) begin
      rd_chk(maps[i]);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] cd;
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010;
    hwdata = 32'h0; sync_diff_n = 1'b1; general_pin_four = 1'b1; sysref = 1'b0;
    err_total = 0; checks_done = 0; seed = 32'h1d0d;
    maps = '{32'hd8, 32'hdc, 32'hf8, dec_adr(0, 0), dec_adr(0, 1), dec_adr(1, 0), dec_adr(1, 1)};
    foreach (maps[i]) mdl[maps[i]] = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_out(pll_mult, ptab[0]);
    chk_out(chan_cfg[0], cfg_exp(1'b0));
    chk_out(chan_cfg[1], cfg_exp(1'b1));
    chk_out(sysref_evt, 32'h0);
    check_all_regs();
    end_test("reset");
    for (int c = 0; c < 4; c++) begin
      // The forty_times_enable_field field lives outside this block; software still sets it with the PLL code.
      wr(32'h0000_0058, (c == 2) ? 32'h70 : 32'h00);
      wr({14'h0, ADR_PLL_FACTOR}, c);
      rd_chk({14'h0, ADR_PLL_FACTOR});
      #1;
      chk_out(pll_mult, ptab[c]);
    end
    end_test("pll");
    for (int ch = 0; ch < 2; ch++) begin
      for (int code = 0; code < 16; code++) begin
        d = rnd();
        wr(dec_adr(ch, 16'h0), {31'h0, d[0]});
        wr(dec_adr(ch, 16'h1), code);
        rd_chk(dec_adr(ch, 16'h1));
        #1;
        chk_out(chan_cfg[ch], cfg_exp(ch));
        chk_out(chan_cfg[1 - ch], cfg_exp(1 - ch));
      end
    end
    end_test("decimation");
    for (int s = 0; s < 2; s++) begin
      wr({14'h0, ADR_SYNC_SEL}, s << SYNC_SEL_BIT);
      repeat (16) begin
        @(posedge clk);
        d = rnd();
        sync_diff_n      <= d[0];
        general_pin_four <= d[1];
        @(posedge clk);
        #1;
        chk_out(sync_req_n, s ? d[1] : d[0]);
      end
    end
    end_test("sync");
    for (int m = 0; m < 4; m++) begin
      cd = m;
      wr({14'h0, ADR_SYSREF_MASK}, m << NCO_MASK_BIT);
      rd_chk({14'h0, ADR_SYSREF_MASK});
      @(posedge clk);
      sysref <= 1'b1;
      @(posedge clk);
      #1;
      chk_out(sysref_evt, {~cd[1], ~cd[0], ~cd[0]});
      @(posedge clk);
      #1;
      chk_out(sysref_evt, 32'h0);
      @(posedge clk);
      sysref <= 1'b0;
    end
    end_test("sysref");
    wr(32'h0000_00d4, 32'hff);
    rd_chk(32'h0000_00d4);
    wr(32'h8000_00d8, 32'h00);
    rd_chk({14'h0, ADR_SYNC_SEL});
    end_test("unmapped");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (maps[i]) mdl[maps[i]] = 32'h0;
    check_all_regs();
    #1;
    chk_out(pll_mult, ptab[0]);
    chk_out(chan_cfg[1], cfg_exp(1'b1));
    end_test("second reset");
    close_out();
  end
endmodule
